// *** mbrse_engine.sv ***
// Purpose: serial slave engine, read holding and write single register
// Assumes: byte receiver/transmitter on the same clock, half duplex
// Notes: replies are built on the fly; register values are fetched
// one word at a time, the unit and scaled words locally, the rest through the holding register port
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - frames delimited by 3.5 character silent gap
// - answer only frames for own station
// - only read (03) and write (06) functions
// - exception reply sets 0x80 on function
// - check bytes low first, then high
// - read reply: address, function, count, words
// - write request: register and value, high first
// - good write echoes request, else exception
// - more than 125 registers is exception
// - bad start or end register gives 02
// - unsupported function gives code 01
// - disallowed data value gives code 03
// - failure during action gives code 04
// - exception frame: address, function, code, check
// - scaled reading served as value minus one
// - unit word allows at most one unit bit
// - log reads start on sample boundary
module mbrse_engine
	import mbrse_pkg::*;
#(
	parameter int unsigned GAP_CYCLES = int'(GAP_CYC_DEF)
)(
	input wire logic I_SYS_CLK,
	input wire logic I_RST,
	input wire logic [7:0] I_RX_DATA,
	input wire logic I_RX_VALID,
	output logic [7:0] O_TX_DATA,
	output logic O_TX_VALID,
	input wire logic I_TX_READY,
	output logic [15:0] O_REG_ADDR,
	output logic O_REG_RD,
	output logic O_REG_WR,
	output logic [15:0] O_REG_WDATA,
	input wire logic [15:0] I_REG_RDATA,
	input wire logic I_REG_ERR,
	input wire logic [7:0] I_BUS_ADDR,
	input wire logic [31:0] I_BUS_WDATA,
	input wire logic I_BUS_WR,
	input wire logic I_BUS_RD,
	output logic [31:0] O_BUS_RDATA,
	output logic O_BUSY
);
	localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(GAP_CYCLES - 1);

	// at most one bit of a field set
	function automatic logic onehot0(input logic [6:0] v);
		return (v & (v - 7'h01)) == 7'h00;
	endfunction
	// register belongs to the plain map
	function automatic logic in_main(input logic [16:0] a);
		return a <= {1'b0, MAP_LAST};
	endfunction
	// register belongs to the log area
	function automatic logic in_log(input logic [16:0] a);
		return a >= {1'b0, LOG_BASE} && a <= {1'b0, LOG_LAST};
	endfunction

	mbrse_state_t state_q; // engine state
	mbrse_kind_t kind_q; // kind of reply under way
	logic [7:0] rx_buf_q [0:7]; // first eight request bytes
	logic [4:0] rx_cnt_q; // bytes in frame, saturating
	logic [GAP_W-1:0] idle_q; // cycles of line silence
	logic [7:0] station_q; // own station address
	logic [6:0] unit_q; // moisture unit selection
	logic [15:0] scaled_q; // reading in hundredths
	logic [7:0] fc_q; // latched function code
	logic [7:0] exc_q; // latched exception code
	logic [15:0] ra_q; // latched register number
	logic [15:0] rv_q; // latched count or value
	logic [15:0] ptr_q; // next register to fetch
	logic [15:0] word_q; // fetched register word
	logic [8:0] idx_q; // reply byte index
	logic [7:0] tx_q; // byte on the transmit port
	logic [15:0] okcnt_q; // frames answered
	logic [15:0] crcerr_q; // frames dropped on check
	logic [31:0] rdata_q; // local port read data
	logic [15:0] rx_crc, tx_crc; // check remainders

	// receive side decode
	wire rx_take = I_RX_VALID && state_q == S_IDLE;
	wire gap_hit = idle_q >= GAP_LAST;
	wire frame_end = state_q == S_IDLE && rx_cnt_q != 5'h00
		&& gap_hit && !I_RX_VALID;
	wire crc_ok = rx_crc == 16'h0000;
	wire addr_ok = rx_buf_q[0] == station_q;
	wire len_ok = rx_cnt_q >= MIN_LEN;
	wire accept = crc_ok && addr_ok && len_ok;
	wire [7:0] fc = rx_buf_q[1];
	wire [15:0] ra = {rx_buf_q[2], rx_buf_q[3]};
	wire [15:0] rv = {rx_buf_q[4], rx_buf_q[5]};
	wire is_rd = fc == FC_READ;
	wire is_wr = fc == FC_WRITE;
	wire [16:0] rd_end = {1'b0, ra} + {1'b0, rv} - 17'h0_0001;
	wire log_start = in_log({1'b0, ra}) && ra[2:0] == 3'h0;
	wire rd_addr_ok = (in_main({1'b0, ra}) && in_main(rd_end))
		|| (log_start && in_log(rd_end));
	wire qty_bad = rv == 16'h0000 || rv > MAX_QTY;
	wire wr_addr_ok = in_main({1'b0, ra}) && ra != SCALED_REG;
	wire wr_val_ok = ra != UNIT_REG || (onehot0(rv[6:0])
		&& rv[15:7] == 9'h000);

	// exception choice, in order of precedence
	logic [7:0] exc_d;
	always_comb begin
		if (!is_rd && !is_wr) begin
			exc_d = EXC_FN;
		end else if (rx_cnt_q != REQ_LEN) begin
			exc_d = EXC_VAL;
		end else if (is_rd && qty_bad) begin
			exc_d = EXC_VAL;
		end else if (is_rd && !rd_addr_ok) begin
			exc_d = EXC_ADDR;
		end else if (is_wr && !wr_addr_ok) begin
			exc_d = EXC_ADDR;
		end else if (is_wr && !wr_val_ok) begin
			exc_d = EXC_VAL;
		end else begin
			exc_d = EXC_NONE;
		end
	end

	// reply layout
	wire [8:0] body = (kind_q == K_READ) ? 9'h003 + {rv_q[7:0], 1'b0}
		: (kind_q == K_ECHO) ? 9'h006 : 9'h003;
	wire need_word = kind_q == K_READ && idx_q >= 9'h003
		&& idx_q < body && idx_q[0];
	wire tx_done = state_q == S_SEND && I_TX_READY;
	wire local_unit = ptr_q == UNIT_REG;
	wire local_scaled = ptr_q == SCALED_REG;
	wire [15:0] word_in = local_unit ? {9'h000, unit_q}
		: local_scaled ? scaled_q - 16'h0001
		: I_REG_RDATA;

	// next reply byte for the current index
	logic [7:0] byte_sel;
	always_comb begin
		if (idx_q == body) begin
			byte_sel = tx_crc[7:0];
		end else if (idx_q == body + 9'h001) begin
			byte_sel = tx_crc[15:8];
		end else if (idx_q == 9'h000) begin
			byte_sel = station_q;
		end else if (idx_q == 9'h001) begin
			byte_sel = (kind_q == K_EXC) ? (fc_q | FC_EXC_FLAG)
				: fc_q;
		end else if (kind_q == K_EXC) begin
			byte_sel = exc_q;
		end else if (kind_q == K_ECHO) begin
			byte_sel = rx_buf_q[idx_q[2:0]];
		end else if (idx_q == 9'h002) begin
			byte_sel = {rv_q[6:0], 1'b0};
		end else begin
			byte_sel = word_q[7:0];
		end
	end

	// receive checks, reply checks on the way out
	mbrse_crc16 u_rx_crc (
		.i_clk(I_SYS_CLK),
		.i_rst(I_RST),
		.i_init(frame_end),
		.i_en(rx_take),
		.i_data(I_RX_DATA),
		.o_crc(rx_crc)
	);
	mbrse_crc16 u_tx_crc (
		.i_clk(I_SYS_CLK),
		.i_rst(I_RST),
		.i_init(frame_end),
		.i_en(tx_done && idx_q < body),
		.i_data(tx_q),
		.o_crc(tx_crc)
	);

	// silence timer; each byte taken in idle or sent restarts it
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || rx_take || tx_done) begin
			idle_q <= '0;
		end else if (!gap_hit) begin
			idle_q <= idle_q + 1'b1;
		end
	end

	// frame collection; bytes during a reply are not taken
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || frame_end) begin
			rx_cnt_q <= '0;
		end else if (rx_take) begin
			if (rx_cnt_q < REQ_LEN) begin
				rx_buf_q[rx_cnt_q[2:0]] <= I_RX_DATA;
			end
			if (rx_cnt_q != 5'h1F) begin
				rx_cnt_q <= rx_cnt_q + 1'b1;
			end
		end
	end

	// message sequencer
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			state_q <= S_IDLE;
			kind_q <= K_EXC;
			fc_q <= '0;
			exc_q <= '0;
			ra_q <= '0;
			rv_q <= '0;
			ptr_q <= '0;
			word_q <= '0;
			idx_q <= '0;
			tx_q <= '0;
		end else begin
			unique case (state_q)
			S_IDLE: begin
				// gap already seen, so the reply may start at once
				if (frame_end && accept) begin
					fc_q <= fc;
					exc_q <= exc_d;
					ra_q <= ra;
					rv_q <= rv;
					ptr_q <= ra;
					idx_q <= '0;
					if (exc_d != EXC_NONE) begin
						kind_q <= K_EXC;
						state_q <= S_LOAD;
					end else if (is_wr) begin
						kind_q <= K_ECHO;
						state_q <= S_WRITE;
					end else begin
						kind_q <= K_READ;
						state_q <= S_LOAD;
					end
				end
			end
			S_WRITE: begin
				state_q <= S_WACK;
			end
			S_WACK: begin
				// target reports failure one cycle after the strobe
				if (I_REG_ERR) begin
					kind_q <= K_EXC;
					exc_q <= EXC_FAIL;
				end
				state_q <= S_LOAD;
			end
			S_LOAD: begin
				if (idx_q == body + 9'h002) begin
					state_q <= S_IDLE;
				end else if (need_word) begin
					state_q <= S_FETCH;
				end else begin
					tx_q <= byte_sel;
					state_q <= S_SEND;
				end
			end
			S_FETCH: begin
				state_q <= S_WORD;
			end
			S_WORD: begin
				word_q <= word_in;
				tx_q <= word_in[15:8];
				ptr_q <= ptr_q + 16'h0001;
				state_q <= S_SEND;
			end
			S_SEND: begin
				if (I_TX_READY) begin
					idx_q <= idx_q + 9'h001;
					state_q <= S_LOAD;
				end
			end
			endcase
		end
	end

	// local settings and counters
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			station_q <= STATION_RST;
			unit_q <= UNIT_RST;
			scaled_q <= '0;
			okcnt_q <= '0;
			crcerr_q <= '0;
		end else begin
			// addresses outside 1..247 are not taken
			if (I_BUS_WR && I_BUS_ADDR == OFS_STATION
				&& I_BUS_WDATA[7:0] != 8'h00
				&& I_BUS_WDATA[7:0] <= STATION_MAX) begin
				station_q <= I_BUS_WDATA[7:0];
			end
			if (I_BUS_WR && I_BUS_ADDR == OFS_SCALED) begin
				scaled_q <= I_BUS_WDATA[15:0];
			end
			if (state_q == S_WACK && !I_REG_ERR && ra_q == UNIT_REG) begin
				unit_q <= rv_q[6:0];
			end
			if (frame_end && accept) begin
				okcnt_q <= okcnt_q + 16'h0001;
			end
			if (frame_end && !crc_ok) begin
				crcerr_q <= crcerr_q + 16'h0001;
			end
		end
	end

	// local read decode, data valid the cycle after the strobe
	logic [31:0] rd_mux;
	always_comb begin
		unique case (I_BUS_ADDR)
		OFS_STATION: rd_mux = {24'h00_0000, station_q};
		OFS_STATUS: rd_mux = {31'h0000_0000, O_BUSY};
		OFS_UNIT: rd_mux = {25'h000_0000, unit_q};
		OFS_SCALED: rd_mux = {16'h0000, scaled_q};
		OFS_OKCNT: rd_mux = {16'h0000, okcnt_q};
		OFS_CRCERR: rd_mux = {16'h0000, crcerr_q};
		default: rd_mux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= I_BUS_RD ? rd_mux : 32'h0000_0000;
		end
	end

	assign O_BUS_RDATA = rdata_q;
	assign O_BUSY = state_q != S_IDLE;
	assign O_TX_DATA = tx_q;
	assign O_TX_VALID = state_q == S_SEND;
	assign O_REG_ADDR = (state_q == S_WRITE) ? ra_q : ptr_q;
	assign O_REG_RD = state_q == S_FETCH && !local_unit && !local_scaled;
	assign O_REG_WR = state_q == S_WRITE;
	assign O_REG_WDATA = rv_q;

	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RST);

	a_gap_holds: assert property (rx_take |=> !frame_end [*2])
		else $error("frame closed without a silent gap");
	a_foreign_drop: assert property (
		frame_end && !addr_ok |=> state_q == S_IDLE [*3])
		else $error("reply to a foreign station");
	a_bad_crc_drop: assert property (
		frame_end && !crc_ok |=> !O_TX_VALID [*4])
		else $error("reply to a corrupted frame");
	a_illegal_fn: assert property (
		frame_end && accept && !is_rd && !is_wr
		|=> exc_q == EXC_FN && kind_q == K_EXC)
		else $error("unsupported function not refused");
	a_qty_limit: assert property (
		frame_end && accept && is_rd && rx_cnt_q == REQ_LEN
		&& rv > MAX_QTY |=> exc_q == EXC_VAL)
		else $error("oversize read not refused");
	a_exc_fn_byte: assert property (
		O_TX_VALID && kind_q == K_EXC && idx_q == 9'h001
		|-> O_TX_DATA == (rx_buf_q[1] | FC_EXC_FLAG))
		else $error("exception function byte wrong");
	a_crc_low_first: assert property (
		O_TX_VALID && idx_q == body |-> O_TX_DATA == tx_crc[7:0])
		else $error("check low byte out of place");
	a_byte_count: assert property (
		O_TX_VALID && kind_q == K_READ && idx_q == 9'h002
		|-> O_TX_DATA == {rx_buf_q[5][6:0], 1'b0})
		else $error("byte count not twice the quantity");
	a_echo_value: assert property (
		O_TX_VALID && kind_q == K_ECHO && idx_q == 9'h004
		|-> O_TX_DATA == rv_q[15:8])
		else $error("write echo differs from request");
	a_unit_single: assert property (onehot0(unit_q))
		else $error("more than one unit selected");
	a_write_fail: assert property (
		state_q == S_WACK && I_REG_ERR |=> exc_q == EXC_FAIL)
		else $error("write failure not reported");
endmodule
`default_nettype wire

// *** mbrse_pkg.sv ***
// Purpose: shared constants and types of the serial slave message engine
// Assumes: 40 MHz system clock, byte-wide receive and transmit ports
// Notes: holding-register offsets are 16-bit network register numbers
package mbrse_pkg;

	// timing of the silent interval between frames
	localparam longint CLK_HZ = 40_000_000;
	localparam longint BAUD_DEF = 9600;
	localparam longint CHAR_BITS = 11;
	localparam longint GAP_TENTHS = 35; // 3.5 character times
	// least gap rounds up to whole cycles
	localparam longint GAP_CYC_DEF =
		(GAP_TENTHS * CHAR_BITS * CLK_HZ + 10 * BAUD_DEF - 1) /
		(10 * BAUD_DEF);
	localparam int GAP_W = 20;

	// frame fields
	localparam logic [7:0] FC_READ = 8'h03;
	localparam logic [7:0] FC_WRITE = 8'h06;
	localparam logic [7:0] FC_EXC_FLAG = 8'h80;
	localparam logic [4:0] REQ_LEN = 5'h08;
	localparam logic [4:0] MIN_LEN = 5'h04;
	localparam logic [7:0] STATION_MAX = 8'hF7;
	localparam logic [7:0] STATION_RST = 8'h01;

	// exception codes
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_FN = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_VAL = 8'h03;
	localparam logic [7:0] EXC_FAIL = 8'h04;

	// holding register map
	localparam logic [15:0] MAX_QTY = 16'h007D;
	localparam logic [15:0] MAP_LAST = 16'h0057;
	localparam logic [15:0] LOG_BASE = 16'h0100;
	localparam logic [15:0] LOG_LAST = 16'h05B0;
	localparam logic [15:0] UNIT_REG = 16'h0003;
	localparam logic [15:0] SCALED_REG = 16'h0004;
	localparam logic [6:0] UNIT_RST = 7'h01;

	// local register port offsets
	localparam logic [7:0] OFS_STATION = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_UNIT = 8'h08;
	localparam logic [7:0] OFS_SCALED = 8'h0C;
	localparam logic [7:0] OFS_OKCNT = 8'h10;
	localparam logic [7:0] OFS_CRCERR = 8'h14;

	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;

	typedef enum {S_IDLE, S_WRITE, S_WACK, S_LOAD, S_FETCH, S_WORD,
		S_SEND} mbrse_state_t;
	typedef enum {K_READ, K_ECHO, K_EXC} mbrse_kind_t;

endpackage

// *** mbrse_crc16.sv ***
// Purpose: byte-serial check-sum generator, reflected form
// Assumes: one data byte per enable cycle
// Notes: feeding the two check bytes of a good frame leaves zero
`timescale 1ns/1ps
`default_nettype none
module mbrse_crc16
	import mbrse_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_init,
	input wire logic i_en,
	input wire logic [7:0] i_data,
	output logic [15:0] o_crc
);
	logic [15:0] crc_q; // running remainder
	logic [15:0] crc_d; // remainder after this byte

	// eight shift steps, lsb first
	always_comb begin
		crc_d = crc_q ^ {8'h00, i_data};
		for (int i = 0; i < 8; i++) begin
			crc_d = crc_d[0] ? ((crc_d >> 1) ^ CRC_POLY) : (crc_d >> 1);
		end
	end

	// init wins over a byte so a new frame starts clean
	always_ff @(posedge i_clk) begin
		if (i_rst || i_init) begin
			crc_q <= CRC_INIT;
		end else if (i_en) begin
			crc_q <= crc_d;
		end
	end

	assign o_crc = crc_q;
endmodule
`default_nettype wire

// *** mbrse_master.sv ***
// Purpose: stand-in for the serial master on the byte link
// Assumes: one request byte per valid pulse, replies taken on ready
// Notes: ready can stall every other cycle, which can stretch each reply byte
`timescale 1ns/1ps
`default_nettype none
module mbrse_master (
	input wire logic i_clk,
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready
);
	logic [7:0] got_q[$]; // reply bytes in wire order
	bit slow = 1'b0; // stall ready on alternate cycles
	int idle_cyc = 0; // cycles since the last line activity
	int first_gap = -1; // silence seen when the reply started

	initial begin
		o_rx_data = 8'h00;
		o_rx_valid = 1'b0;
		o_tx_ready = 1'b0;
	end

	// collect reply bytes and time the silence ahead of them
	always @(posedge i_clk) begin
		o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
		idle_cyc <= idle_cyc + 1;
		if (o_rx_valid) begin
			idle_cyc <= 0;
		end
		if (i_tx_valid && first_gap < 0) begin
			first_gap <= idle_cyc;
		end
		if (i_tx_valid && o_tx_ready) begin
			got_q.push_back(i_tx_data);
			idle_cyc <= 0;
		end
	end

	// bytes go out whole, in wire order, one pulse each
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			@(posedge i_clk);
			o_rx_data <= b[i];
			o_rx_valid <= 1'b1;
			@(posedge i_clk);
			o_rx_valid <= 1'b0;
			o_rx_data <= ~b[i]; // byte no longer held
		end
	endtask
endmodule
`default_nettype wire

// *** mbrse_engine_tb.sv ***
// Purpose: self-checking bench of the serial slave message engine
// Assumes: holding words come from a stand-in, word = number + 0x1000
// Notes: the silent gap is shortened to 40 cycles to keep runs brief
`timescale 1ns/1ps
`default_nettype none
module mbrse_engine_tb;
	import mbrse_pkg::*;
	typedef logic [7:0] mbrse_bq_t[$];
	localparam int GAP = 40; // shortened silent interval
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] rx_data, tx_data, bus_addr;
	logic rx_valid, tx_valid, tx_ready, busy;
	logic [15:0] reg_addr, reg_wdata;
	logic [15:0] reg_rdata = 16'h0000;
	logic reg_rd, reg_wr;
	logic reg_err = 1'b0;
	logic err_mode = 1'b0; // make holding writes fail
	logic [31:0] wr_seen = 32'h0000_0000; // last holding write
	logic [31:0] bus_wdata = 32'h0000_0000;
	logic [31:0] bus_rdata;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [7:0] st = 8'h01; // station the requests go to
	int errors = 0;
	int checks_done = 0;
	mbrse_bq_t none; // no reply expected
	mbrse_bq_t q;

	always #12.5 clk = ~clk;

	mbrse_engine #(.GAP_CYCLES(GAP)) u_dut (
		.I_SYS_CLK(clk), .I_RST(rst),
		.I_RX_DATA(rx_data), .I_RX_VALID(rx_valid),
		.O_TX_DATA(tx_data), .O_TX_VALID(tx_valid),
		.I_TX_READY(tx_ready),
		.O_REG_ADDR(reg_addr), .O_REG_RD(reg_rd), .O_REG_WR(reg_wr),
		.O_REG_WDATA(reg_wdata), .I_REG_RDATA(reg_rdata),
		.I_REG_ERR(reg_err),
		.I_BUS_ADDR(bus_addr), .I_BUS_WDATA(bus_wdata),
		.I_BUS_WR(bus_wr), .I_BUS_RD(bus_rd),
		.O_BUS_RDATA(bus_rdata), .O_BUSY(busy)
	);

	mbrse_master u_master (
		.i_clk(clk), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
		.i_tx_data(tx_data), .i_tx_valid(tx_valid),
		.o_tx_ready(tx_ready)
	);

	// holding register stand-in; error answers the write cycle
	always @(posedge clk) begin
		if (reg_rd) begin
			reg_rdata <= reg_addr + 16'h1000;
		end
		reg_err <= reg_wr & err_mode;
		if (reg_wr) begin
			wr_seen <= {reg_addr, reg_wdata};
		end
	end

	task automatic cmp(input string n, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic tend(input string n);
		$display("done: %s", n);
	endtask

	// reflected check sum appended low byte first
	function automatic mbrse_bq_t fcs(input mbrse_bq_t b);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		return b;
	endfunction

	// request: station, function, two 16-bit fields high first
	function automatic mbrse_bq_t rq(input logic [7:0] f,
			input logic [15:0] a, v);
		return '{st, f, a[15:8], a[7:0], v[15:8], v[7:0]};
	endfunction

	function automatic mbrse_bq_t exc(input logic [7:0] f, c);
		return '{st, f | FC_EXC_FLAG, c};
	endfunction

	// read reply built from the stand-in's word pattern
	function automatic mbrse_bq_t rdx(input logic [15:0] a, input int n);
		mbrse_bq_t r;
		logic [15:0] w;
		r = '{st, FC_READ, 8'(2 * n)};
		for (int i = 0; i < n; i++) begin
			w = a + 16'(i) + 16'h1000;
			r.push_back(w[15:8]);
			r.push_back(w[7:0]);
		end
		return r;
	endfunction

	// one frame out, whole reply compared; bad spoils the check
	task automatic go(input mbrse_bq_t req, exp, input bit bad);
		int n;
		req = fcs(req);
		if (bad)
			req[$] ^= 8'h01;
		if (exp.size() > 0)
			exp = fcs(exp);
		u_master.got_q.delete();
		u_master.first_gap = -1;
		u_master.send(req);
		repeat (GAP + 6) @(posedge clk);
		for (n = 0; n < 4000 && busy === 1'b1; n++)
			@(posedge clk);
		if (n == 4000) begin
			errors++;
			finish_test();
		end
		repeat (GAP + 4) @(posedge clk);
		cmp("reply length", exp.size(), u_master.got_q.size());
		foreach (exp[i])
			cmp("reply byte", exp[i], u_master.got_q[i]);
		if (exp.size() > 0)
			cmp("silence first", 1, u_master.first_gap >= GAP);
	endtask

	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic bus_read(input string n, input logic [7:0] a,
			input logic [31:0] e);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		@(negedge clk);
		cmp(n, e, bus_rdata);
		@(posedge clk);
		// data must fall back to zero once its cycle is over
		@(negedge clk);
		cmp({n, " cleared"}, 32'h0000_0000, bus_rdata);
		@(posedge clk);
	endtask

	initial begin
		bus_addr = 8'h00;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus_read("station", OFS_STATION, 32'h0000_0001);
		bus_read("unit", OFS_UNIT, 32'h0000_0001);
		bus_read("hole", 8'h20, 32'h0000_0000);
		bus_read("status", OFS_STATUS, 32'h0000_0000);
		tend("defaults");
		u_master.slow = 1'b1;
		go(rq(FC_READ, 16'h0007, 16'h0002), rdx(16'h0007, 2), 0);
		u_master.slow = 1'b0;
		tend("read");
		q = rq(FC_WRITE, 16'h0015, 16'hFC18);
		go(q, q, 0);
		cmp("holding write", 32'h0015_FC18, wr_seen);
		err_mode <= 1'b1;
		go(q, exc(FC_WRITE, EXC_FAIL), 0);
		err_mode <= 1'b0;
		tend("write");
		st = 8'h02;
		go(rq(FC_READ, 16'h0007, 16'h0001), none, 0);
		st = 8'h01;
		go(rq(FC_READ, 16'h0007, 16'h0001), none, 1);
		bus_read("drops", OFS_CRCERR, 32'h0000_0001);
		q = '{st};
		go(q, none, 0);
		bus_read("answered", OFS_OKCNT, 32'h0000_0003);
		q = '{st, FC_READ, 8'h00, 8'h07, 8'h01};
		go(q, exc(FC_READ, EXC_VAL), 0);
		tend("silent");
		q = '{8'h02, 8'h04, 8'h10};
		foreach (q[i])
			go(rq(q[i], 16'h0000, 16'h0001), exc(q[i], EXC_FN), 0);
		tend("functions");
		go(rq(FC_READ, LOG_BASE, 16'h007E), exc(FC_READ, EXC_VAL), 0);
		go(rq(FC_READ, LOG_BASE, MAX_QTY), rdx(LOG_BASE, 125), 0);
		go(rq(FC_READ, 16'h0101, 16'h0001), exc(FC_READ, EXC_ADDR), 0);
		go(rq(FC_READ, 16'h0050, 16'h0009), exc(FC_READ, EXC_ADDR), 0);
		go(rq(FC_READ, 16'h0007, 16'h0000), exc(FC_READ, EXC_VAL), 0);
		go(rq(FC_READ, 16'h05A8, 16'h000A), exc(FC_READ, EXC_ADDR), 0);
		go(rq(FC_READ, 16'h05A8, 16'h0008), rdx(16'h05A8, 8), 0);
		tend("ranges");
		go(rq(FC_WRITE, UNIT_REG, 16'h0006), exc(FC_WRITE, EXC_VAL), 0);
		go(rq(FC_WRITE, SCALED_REG, 16'h0001),
			exc(FC_WRITE, EXC_ADDR), 0);
		q = rq(FC_WRITE, UNIT_REG, 16'h0040);
		go(q, q, 0);
		bus_read("unit", OFS_UNIT, 32'h0000_0040);
		bus_write(OFS_SCALED, 32'h0000_09C4);
		q = '{st, FC_READ, 8'h02, 8'h09, 8'hC3};
		go(rq(FC_READ, SCALED_REG, 16'h0001), q, 0);
		tend("formats");
		bus_write(OFS_STATION, 32'h0000_00F8);
		bus_read("station", OFS_STATION, 32'h0000_0001);
		bus_write(OFS_STATION, 32'h0000_0022);
		st = 8'h22;
		go(rq(FC_READ, 16'h0007, 16'h0001), rdx(16'h0007, 1), 0);
		tend("station");
		finish_test();
	end
endmodule
`default_nettype wire
